// *** hdl/tvo_timing_regs.sv ***
// tv output level controls and parallel video timing windows, apb slave
// assumes apb master on clk, synchronous active-low reset, one clock only
// What this block does
// - burst amplitude code gives 30..180 percent
// - sync pedestal code passes straight as lsbs
// - enable bit gates parallel interface, resets off
// - mode bit 2 selects pixel clock launch edge
// - mode bit 1 selects 625 or 525 lines
// - odd field active lines start through end
// - even field active lines start through end
// - line positions count first line as one
// - active pixels from pixel start through end
// - pixel positions counted from eav, 0..720
`timescale 1ns/100ps
`default_nettype none
module tvo_timing_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] pix_data_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic vid_pclk,
  output logic [7:0] vid_data,
  output logic vid_active,
  output logic vid_field_even,
  output logic [7:0] burst_amp_pct,
  output logic [6:0] sync_pedestal_out
);
  import tvo_pkg::*;

  function automatic logic in_window(input logic [9:0] pos, input logic [9:0] lo, input logic [9:0] hi);
    in_window = (pos >= lo) && (pos <= hi);
  endfunction

  logic [3:0] burst_amp_level_reg;
  logic [6:0] sync_pedestal_level_reg;
  logic parallel_if_on_reg;
  logic pixclk_edge_sel_reg;
  logic line_standard_sel_reg;
  logic [7:0] odd_line_start_reg;
  logic [8:0] odd_line_end_reg;
  logic [9:0] even_line_start_reg;
  logic [9:0] even_line_end_reg;
  logic [9:0] pixel_window_start_reg;
  logic [9:0] pixel_window_end_reg;

  logic [9:0] pix_cnt;
  logic [9:0] line_cnt;
  logic field_even;
  logic step;
  logic [9:0] htotal;
  logic line_act;
  logic pix_act;
  tvo_out_type out_next;
  logic [7:0] data_next;
  logic [31:0] rdata_next;
  logic map_hit;
  logic wr_en;

  // apb: setup cycle latches the answer, first access cycle completes
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    map_hit = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      OFF_BURST: rdata_next[3:0] = burst_amp_level_reg;
      OFF_SYNC: rdata_next[6:0] = sync_pedestal_level_reg;
      OFF_IF_ENABLE: rdata_next[BIT_IF_ON] = parallel_if_on_reg;
      OFF_IF_MODE: begin
        rdata_next[BIT_EDGE_SEL] = pixclk_edge_sel_reg;
        rdata_next[BIT_STD_SEL] = line_standard_sel_reg;
      end
      OFF_ODD_WIN: begin
        rdata_next[7:0] = odd_line_start_reg;
        rdata_next[FLD_END_LSB +: 9] = odd_line_end_reg;
      end
      OFF_EVEN_WIN: begin
        rdata_next[9:0] = even_line_start_reg;
        rdata_next[FLD_END_LSB +: 10] = even_line_end_reg;
      end
      OFF_PIX_WIN: begin
        rdata_next[9:0] = pixel_window_start_reg;
        rdata_next[FLD_END_LSB +: 10] = pixel_window_end_reg;
      end
      OFF_RASTER_STAT: begin
        rdata_next[9:0] = pix_cnt;
        rdata_next[FLD_END_LSB +: 10] = line_cnt;
        rdata_next[BIT_STAT_FIELD] = field_even;
      end
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !map_hit;
      prdata <= (pwrite || !map_hit) ? 32'h0000_0000 : rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // status register is read-only, writes to it are dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      burst_amp_level_reg <= RST_BURST;
      sync_pedestal_level_reg <= RST_SYNC;
    end else if (wr_en && paddr == OFF_BURST) begin
      burst_amp_level_reg <= pwdata[3:0];
    end else if (wr_en && paddr == OFF_SYNC) begin
      sync_pedestal_level_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      parallel_if_on_reg <= 1'b0;
      pixclk_edge_sel_reg <= 1'b0;
      line_standard_sel_reg <= 1'b0;
    end else if (wr_en && paddr == OFF_IF_ENABLE) begin
      parallel_if_on_reg <= pwdata[BIT_IF_ON];
    end else if (wr_en && paddr == OFF_IF_MODE) begin
      pixclk_edge_sel_reg <= pwdata[BIT_EDGE_SEL];
      line_standard_sel_reg <= pwdata[BIT_STD_SEL];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      odd_line_start_reg <= 8'h00;
      odd_line_end_reg <= 9'h000;
      even_line_start_reg <= 10'h000;
      even_line_end_reg <= 10'h000;
      pixel_window_start_reg <= 10'h000;
      pixel_window_end_reg <= 10'h000;
    end else if (wr_en && paddr == OFF_ODD_WIN) begin
      odd_line_start_reg <= pwdata[7:0];
      odd_line_end_reg <= pwdata[FLD_END_LSB +: 9];
    end else if (wr_en && paddr == OFF_EVEN_WIN) begin
      even_line_start_reg <= pwdata[9:0];
      even_line_end_reg <= pwdata[FLD_END_LSB +: 10];
    end else if (wr_en && paddr == OFF_PIX_WIN) begin
      pixel_window_start_reg <= pwdata[9:0];
      pixel_window_end_reg <= pwdata[FLD_END_LSB +: 10];
    end
  end

  // level outputs, one flop after the register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      burst_amp_pct <= BURST_BASE_PCT + BURST_STEP_PCT * {4'h0, RST_BURST};
      sync_pedestal_out <= RST_SYNC;
    end else begin
      burst_amp_pct <= BURST_BASE_PCT + BURST_STEP_PCT * {4'h0, burst_amp_level_reg};
      sync_pedestal_out <= sync_pedestal_level_reg;
    end
  end

  // pixel clock is clk/2; data launches when pclk moves to the chosen edge
  assign step = parallel_if_on_reg && (vid_pclk == pixclk_edge_sel_reg);

  always_ff @(posedge clk) begin
    if (!resetn || !parallel_if_on_reg) begin
      vid_pclk <= 1'b0;
    end else begin
      vid_pclk <= ~vid_pclk;
    end
  end

  tvo_raster u_raster (
    .clk(clk),
    .resetn(resetn),
    .clr(!parallel_if_on_reg),
    .step(step),
    .std_525(line_standard_sel_reg),
    .pix_cnt(pix_cnt),
    .line_cnt(line_cnt),
    .field_even(field_even)
  );

  assign htotal = line_standard_sel_reg ? HTOTAL_525 : HTOTAL_625;

  always_comb begin
    if (field_even) begin
      line_act = in_window(line_cnt, even_line_start_reg, even_line_end_reg);
    end else begin
      line_act = in_window(line_cnt, {2'h0, odd_line_start_reg}, {1'h0, odd_line_end_reg});
    end
    // window clipped to 720 past the eav code
    pix_act = in_window(pix_cnt, pixel_window_start_reg, pixel_window_end_reg) && pix_cnt <= PIX_MAX;
  end

  // code byte: 1, field, vertical blank, h (1 = eav at pixel 0, 0 = sav at line end)
  always_comb begin
    out_next = OUT_BLANK;
    data_next = DATA_BLANK;
    if (!parallel_if_on_reg) begin
      out_next = OUT_IDLE;
      data_next = DATA_IDLE;
    end else if (pix_cnt == 10'h000) begin
      out_next = OUT_CODE;
      data_next = {1'b1, field_even, !line_act, 1'b1, 4'h0};
    end else if (pix_cnt == htotal - 10'h001) begin
      out_next = OUT_CODE;
      data_next = {1'b1, field_even, !line_act, 1'b0, 4'h0};
    end else if (line_act && pix_act) begin
      out_next = OUT_ACT;
      data_next = pix_data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !parallel_if_on_reg) begin
      vid_data <= DATA_IDLE;
      vid_active <= 1'b0;
      vid_field_even <= 1'b0;
    end else if (step) begin
      case (out_next)
        OUT_IDLE: begin
          vid_data <= DATA_IDLE;
          vid_active <= 1'b0;
        end
        OUT_BLANK, OUT_CODE: begin
          vid_data <= data_next;
          vid_active <= 1'b0;
        end
        OUT_ACT: begin
          vid_data <= data_next;
          vid_active <= 1'b1;
        end
        default: begin
          vid_data <= DATA_IDLE;
          vid_active <= 1'b0;
        end
      endcase
      vid_field_even <= field_even;
    end
  end

  property p_burst_level;
    @(posedge clk) disable iff (!resetn)
    $stable(burst_amp_level_reg) |=> burst_amp_pct == BURST_BASE_PCT + BURST_STEP_PCT * 8'($past(burst_amp_level_reg));
  endproperty
  a_burst_level: assert property (p_burst_level) else $error("burst percent wrong");

  property p_sync_level;
    @(posedge clk) disable iff (!resetn)
    ##1 sync_pedestal_out == $past(sync_pedestal_level_reg);
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("sync pedestal not passed");

  property p_if_off_idle;
    @(posedge clk) disable iff (!resetn)
    !parallel_if_on_reg [*2] |-> vid_data == DATA_IDLE && !vid_active && !vid_pclk;
  endproperty
  a_if_off_idle: assert property (p_if_off_idle) else $error("output not idle while off");

  property p_launch_edge;
    @(posedge clk) disable iff (!resetn)
    parallel_if_on_reg && $past(parallel_if_on_reg) && $stable(pixclk_edge_sel_reg) && $changed(vid_data)
      |-> vid_pclk == !pixclk_edge_sel_reg;
  endproperty
  a_launch_edge: assert property (p_launch_edge) else $error("data launched on wrong edge");

  property p_field_length;
    @(posedge clk) disable iff (!resetn)
    line_cnt <= (line_standard_sel_reg ? ODD_LINES_525 : ODD_LINES_625) && pix_cnt < htotal;
  endproperty
  a_field_length: assert property (p_field_length) else $error("raster past field length");

  property p_odd_window;
    @(posedge clk) disable iff (!resetn)
    $rose(vid_active) && !$past(field_even)
      |-> $past(line_cnt) >= {2'h0, odd_line_start_reg} && $past(line_cnt) <= {1'h0, odd_line_end_reg};
  endproperty
  a_odd_window: assert property (p_odd_window) else $error("odd field line outside window");

  property p_even_window;
    @(posedge clk) disable iff (!resetn)
    $rose(vid_active) && $past(field_even)
      |-> $past(line_cnt) >= even_line_start_reg && $past(line_cnt) <= even_line_end_reg;
  endproperty
  a_even_window: assert property (p_even_window) else $error("even field line outside window");

  property p_line_from_one;
    @(posedge clk) disable iff (!resetn)
    !parallel_if_on_reg |=> line_cnt == FIRST_LINE && pix_cnt == 10'h000;
  endproperty
  a_line_from_one: assert property (p_line_from_one) else $error("line count not from one");

  property p_pixel_window;
    @(posedge clk) disable iff (!resetn)
    $rose(vid_active) |-> in_window($past(pix_cnt), pixel_window_start_reg, pixel_window_end_reg);
  endproperty
  a_pixel_window: assert property (p_pixel_window) else $error("pixel outside window");

  property p_eav_code;
    @(posedge clk) disable iff (!resetn)
    step && pix_cnt == 10'h000 |=> vid_data[7] && vid_data[4] && !vid_active && $past(pix_cnt) <= PIX_MAX;
  endproperty
  a_eav_code: assert property (p_eav_code) else $error("eav code missing at pixel 0");

  property p_off_ignores;
    @(posedge clk) disable iff (!resetn)
    $fell(parallel_if_on_reg) |-> ##1 (vid_data == DATA_IDLE && !vid_active) [*3];
  endproperty
  a_off_ignores: assert property (p_off_ignores) else $error("windows not ignored after disable");

  c_active: cover property (@(posedge clk) disable iff (!resetn) $rose(vid_active));
  c_field: cover property (@(posedge clk) disable iff (!resetn) $rose(field_even));
  c_write: cover property (@(posedge clk) disable iff (!resetn) wr_en && paddr == OFF_PIX_WIN);
  c_badaddr: cover property (@(posedge clk) disable iff (!resetn) pready && pslverr);
endmodule
`default_nettype wire

// *** hdl/tvo_pkg.sv ***
// package for the tv output timing and level block
// assumes a single 10 mhz clock with pixels at half that rate and an apb register port
package tvo_pkg;
  localparam logic [11:0] OFF_BURST = 12'h03c;
  localparam logic [11:0] OFF_SYNC = 12'h040;
  localparam logic [11:0] OFF_IF_ENABLE = 12'h100;
  localparam logic [11:0] OFF_IF_MODE = 12'h104;
  localparam logic [11:0] OFF_ODD_WIN = 12'h108;
  localparam logic [11:0] OFF_EVEN_WIN = 12'h10c;
  localparam logic [11:0] OFF_PIX_WIN = 12'h110;
  localparam logic [11:0] OFF_RASTER_STAT = 12'h114;

  localparam logic [3:0] RST_BURST = 4'h7;
  localparam logic [6:0] RST_SYNC = 7'h00;

  localparam int BIT_IF_ON = 0;
  localparam int BIT_STD_SEL = 1;
  localparam int BIT_EDGE_SEL = 2;
  localparam int FLD_END_LSB = 16;
  localparam int BIT_STAT_FIELD = 31;

  localparam logic [7:0] BURST_BASE_PCT = 8'h1e;
  localparam logic [7:0] BURST_STEP_PCT = 8'h0a;

  localparam logic [9:0] HTOTAL_625 = 10'h360;
  localparam logic [9:0] HTOTAL_525 = 10'h35a;
  localparam logic [9:0] ODD_LINES_625 = 10'h139;
  localparam logic [9:0] EVEN_LINES_625 = 10'h138;
  localparam logic [9:0] ODD_LINES_525 = 10'h107;
  localparam logic [9:0] EVEN_LINES_525 = 10'h106;
  localparam logic [9:0] FIRST_LINE = 10'h001;
  localparam logic [9:0] PIX_MAX = 10'h2d0;

  localparam logic [7:0] DATA_IDLE = 8'h00;
  localparam logic [7:0] DATA_BLANK = 8'h80;

  typedef enum logic [3:0] {
    OUT_IDLE = 4'b0001,
    OUT_BLANK = 4'b0010,
    OUT_CODE = 4'b0100,
    OUT_ACT = 4'b1000
  } tvo_out_type;
endpackage

// *** hdl/tvo_raster.sv ***
// pixel, line and field counters for the parallel video raster
// assumes step is a one-cycle pixel enable from the parent
`timescale 1ns/100ps
`default_nettype none
module tvo_raster (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic step,
  input wire logic std_525,
  output logic [9:0] pix_cnt,
  output logic [9:0] line_cnt,
  output logic field_even
);
  import tvo_pkg::*;

  logic [9:0] htotal;
  logic [9:0] field_lines;

  always_comb begin
    htotal = std_525 ? HTOTAL_525 : HTOTAL_625;
    if (std_525) begin
      field_lines = field_even ? EVEN_LINES_525 : ODD_LINES_525;
    end else begin
      field_lines = field_even ? EVEN_LINES_625 : ODD_LINES_625;
    end
  end

  // pixel 0 is the end-of-active-video code
  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      pix_cnt <= 10'h000;
    end else if (step) begin
      pix_cnt <= (pix_cnt >= htotal - 10'h001) ? 10'h000 : pix_cnt + 10'h001;
    end
  end

  // lines restart at 1 in each field
  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      line_cnt <= FIRST_LINE;
      field_even <= 1'b0;
    end else if (step && pix_cnt >= htotal - 10'h001) begin
      if (line_cnt >= field_lines) begin
        line_cnt <= FIRST_LINE;
        field_even <= ~field_even;
      end else begin
        line_cnt <= line_cnt + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tvo_video_rx.sv ***
// video receiver model on the parallel pixel bus, counts active pixels
// assumes pixel clock derived from clk and bytes launched on the chosen edge
`timescale 1ns/100ps
`default_nettype none
module tvo_video_rx (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic on,
  input wire logic edge_sel,
  input wire logic vid_pclk,
  input wire logic [7:0] vid_data,
  input wire logic vid_active,
  input wire logic [7:0] exp_pix,
  output logic [31:0] act_cnt,
  output logic [31:0] first_idx,
  output logic [31:0] last_idx,
  output logic [31:0] line_len,
  output logic [31:0] edge_err,
  output logic [31:0] data_err
);
  logic [31:0] idx;
  logic [7:0] prev_data;
  logic prev_pclk;
  always_ff @(posedge clk) begin
    prev_data <= vid_data;
    prev_pclk <= vid_pclk;
    if (!resetn || clr) begin
      act_cnt <= '0;
      first_idx <= '0;
      last_idx <= '0;
      line_len <= '0;
      edge_err <= '0;
      data_err <= '0;
      idx <= '0;
    end else if (on) begin
      // a byte may only change on the launch edge
      if (vid_data !== prev_data && vid_pclk !== ~edge_sel) edge_err <= edge_err + 1;
      if (vid_pclk === ~edge_sel && vid_pclk !== prev_pclk) begin
        // eav timing reference byte restarts the pixel count at one
        if (vid_data[7] && vid_data[4] && !vid_active) begin
          line_len <= idx;
          idx <= 32'h1;
        end else begin
          idx <= idx + 1;
        end
        if (vid_active) begin
          if (act_cnt == 0) first_idx <= idx;
          last_idx <= idx;
          act_cnt <= act_cnt + 1;
          if (vid_data !== exp_pix) data_err <= data_err + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** test/test_tvo_timing_regs.sv ***
// self-checking bench: apb master, level and window scenarios
// assumes tvo_timing_regs and the receiver model tvo_video_rx
`timescale 1ns/100ps
`default_nettype none
module test_tvo_timing_regs;
  import tvo_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic vid_pclk, vid_active, vid_field_even, rx_clr, rx_on, rx_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, act_cnt, first_idx, last_idx, line_len, edge_err, data_err;
  logic [7:0] pix_data_in, vid_data, burst_amp_pct;
  logic [6:0] sync_pedestal_out;
  int n_errors = 0;
  int checked = 0;
  tvo_timing_regs u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pix_data_in(pix_data_in), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vid_pclk(vid_pclk), .vid_data(vid_data), .vid_active(vid_active),
    .vid_field_even(vid_field_even), .burst_amp_pct(burst_amp_pct), .sync_pedestal_out(sync_pedestal_out));
  tvo_video_rx u_rx (.clk(clk), .resetn(resetn), .clr(rx_clr), .on(rx_on), .edge_sel(rx_sel),
    .vid_pclk(vid_pclk), .vid_data(vid_data), .vid_active(vid_active), .exp_pix(pix_data_in),
    .act_cnt(act_cnt), .first_idx(first_idx), .last_idx(last_idx), .line_len(line_len),
    .edge_err(edge_err), .data_err(data_err));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task results;
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      n_errors++;
      results();
    end
    // answer taken at the completing edge, then the request is released
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task t_reset;
    rdchk("burst", OFF_BURST, 32'h7);
    rdchk("sync", OFF_SYNC, 32'h0);
    rdchk("enable", OFF_IF_ENABLE, 32'h0);
    rdchk("mode", OFF_IF_MODE, 32'h0);
    rdchk("odd", OFF_ODD_WIN, 32'h0);
    rdchk("even", OFF_EVEN_WIN, 32'h0);
    rdchk("pix", OFF_PIX_WIN, 32'h0);
    rdchk("status", OFF_RASTER_STAT, 32'h0001_0000);
    chk("burst_pct", 32'h64, {24'h0, burst_amp_pct});
    chk("idle", 32'h0, {22'h0, vid_data, vid_pclk, vid_active});
    apb(1'b0, 12'h200, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask
  task t_levels;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_BURST, 32'hfffffff0 | c);
      rdchk("burst", OFF_BURST, c);
      chk("burst_pct", 30 + 10 * c, {24'h0, burst_amp_pct});
    end
    for (int s = 0; s < 128; s++) begin
      apb(1'b1, OFF_SYNC, 32'hffffff80 | s);
      rdchk("sync", OFF_SYNC, s);
      chk("sync_out", s, {25'h0, sync_pedestal_out});
    end
    apb(1'b1, OFF_BURST, 32'h7);
  endtask
  // odd window ls..2, pixel window ps..ps+10, then disable
  task t_window(input logic sel, input logic std, input logic [9:0] ls, input logic [9:0] ps);
    apb(1'b1, OFF_IF_MODE, {29'h0, sel, std, 1'b0});
    apb(1'b1, OFF_ODD_WIN, 32'h00020000 | ls);
    apb(1'b1, OFF_PIX_WIN, {6'h0, ps + 10'd10, 6'h0, ps});
    // receiver cleared before enable so its pixel index starts at the first eav
    rx_sel <= sel;
    rx_on <= 1'b1;
    rx_clr <= 1'b1;
    @(posedge clk);
    rx_clr <= 1'b0;
    apb(1'b1, OFF_IF_ENABLE, 32'h1);
    repeat (7000) @(posedge clk);
    chk("act_cnt", 11 * (3 - ls), act_cnt);
    chk("first_idx", ps, first_idx);
    chk("last_idx", ps + 10'd10, last_idx);
    chk("line_len", std ? HTOTAL_525 : HTOTAL_625, line_len);
    chk("edge_err", 32'h0, edge_err);
    chk("data_err", 32'h0, data_err);
    chk("field", 32'h0, {31'h0, vid_field_even});
    rx_on <= 1'b0;
    apb(1'b1, OFF_IF_ENABLE, 32'h0);
    @(posedge clk);
    @(negedge clk);
    chk("off", 32'h0, {22'h0, vid_data, vid_pclk, vid_active});
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pix_data_in = 8'h3c;
    rx_clr = 1'b0;
    rx_on = 1'b0;
    rx_sel = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_levels();
    t_window(1'b0, 1'b0, 10'd1, 10'd10);
    t_window(1'b1, 1'b1, 10'd2, 10'd710);
    results();
  end
  // runs take about 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
